// ==== verilog/drg_defs.vh ====
/*
  constants for the converter register bank: command addresses,
  reset values, field positions and bus addressing.
  assumes inclusion by the bank and its helper modules only.
*/
`ifndef DRG_DEFS_VH
`define DRG_DEFS_VH

`define DRG_CMD_POWER_OP 8'h01
`define DRG_CMD_OUT_CODE 8'h21
`define DRG_CMD_UP_MARGIN 8'h25
`define DRG_CMD_LO_MARGIN 8'h26
`define DRG_CMD_PSTAT_BYTE 8'h78
`define DRG_CMD_BUS_REV 8'h98
`define DRG_CMD_STATUS 8'hD0
`define DRG_CMD_GENERAL 8'hD1
`define DRG_CMD_ALARM_TONE 8'hD2
`define DRG_CMD_TRIGGERS 8'hD3

`define DRG_RST_POWER_OP 16'h0000
`define DRG_RST_CODE 16'h0000
`define DRG_RST_PSTAT_BYTE 16'h0000
`define DRG_RST_BUS_REV 16'h2200
`define DRG_RST_GENERAL 16'h01F0
`define DRG_RST_ALARM_TONE 16'h0000
`define DRG_RST_TRIGGERS 16'h0008

`define DRG_MASK_ALL 16'hFFFF
`define DRG_MASK_CODE10 16'h0FFC
`define DRG_MASK_CODE8 16'h0FF0

`define DRG_ST_USER_CRC 15
`define DRG_ST_FACT_CRC 14
`define DRG_ST_NV_BUSY 13
`define DRG_ST_UPD_BUSY 12
`define DRG_ST_DONTCARE 6'h00
`define DRG_TRIG_PROG 4
`define DRG_TRIG_RELOAD 5

`define DRG_BUS_BASE 4'h9
`define DRG_BUS_BCAST 7'h47
`define DRG_BITS_PER_BYTE 4'h8

`endif

// ==== verilog/drg_reg16.v ====
/*
  one 16-bit software register with reset value and write mask.
  assumes the write enable is a single-cycle strobe from the bank.
*/
`include "drg_defs.vh"

module drg_reg16 #(
  parameter [15:0] RESET_VAL = 16'h0000,
  parameter [15:0] WR_MASK = 16'hFFFF
) (
  input wire mclk,
  input wire rst_n,
  input wire we,
  input wire [15:0] wdata,
  output reg [15:0] q
);

  // masked bits always read zero, so ignored field bits never stick
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RESET_VAL;
    end else if (we) begin
      q <= wdata & WR_MASK;
    end
  end

endmodule

// ==== verilog/drg_busy.v ====
/*
  busy flag: raised by a start strobe, dropped by a done strobe.
  assumes done comes from the attached controller, on mclk.
*/
`include "drg_defs.vh"

module drg_busy (
  input wire mclk,
  input wire rst_n,
  input wire start,
  input wire done,
  output reg busy
);

  // start wins so a new job in the done cycle is not lost
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
    end else if (done) begin
      busy <= 1'b0;
    end
  end

endmodule

// ==== verilog/drg_bank.v ====
/*
  converter register bank behind a two-wire serial slave.
  assumes scl/sda inputs are already synchronous to mclk, the pad
  pulls sda low while sda_oe is high, and the nonvolatile controller
  and output stage answer with single-cycle done strobes.
*/
// Overview of operation
// RQ1 - bit 15 shows user store crc failure
// RQ2 - bit 14 shows factory store crc failure
// RQ3 - bit 13 high during nonvolatile program/reload
// RQ4 - bit 13 clears when nonvolatile job finishes
// RQ5 - bit 12 high while output updates
// RQ6 - bit 12 clears when output update completes
// RQ7 - general settings reset to 01F0h
// RQ8 - action triggers reset to 0008h
// RQ9 - alarm tone settings reset to 0000h
// RQ10 - output and margin codes reset to 0000h
// RQ11 - operation and status byte reset 0000h
// RQ12 - bus revision register returns 2200h
// RQ13 - output code keeps only variant code bits
// RQ14 - margin codes share the output code layout
// RQ15 - status holds identifier and revision fields
// RQ16 - read-only writes ignored, reads have no effects
// RQ17 - read: command, repeated start, upper then lower
// RQ18 - write applies at ack after lower byte
// RQ19 - broadcast address accepted only for writes
`include "drg_defs.vh"

module drg_bank #(
  parameter TEN_BIT = 1,
  parameter [3:0] PART_ID = 4'h5,
  parameter [1:0] REV_ID = 2'h1
) (
  input wire mclk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire [2:0] dev_addr_sel,
  input wire user_crc_fail,
  input wire factory_crc_fail,
  input wire nv_op_done,
  input wire output_update_done,
  output reg nv_prog_req,
  output reg nv_reload_req,
  output reg output_update_req,
  output wire [15:0] power_operation_cmd,
  output wire [15:0] output_code,
  output wire [15:0] upper_margin_code,
  output wire [15:0] lower_margin_code,
  output wire [15:0] power_status_byte,
  output wire [15:0] general_settings,
  output wire [15:0] alarm_tone_settings,
  output wire [15:0] action_triggers,
  output wire nonvolatile_op_pending,
  output wire output_update_busy
);

  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_RX = 5'b00010;
  localparam [4:0] ST_ACK = 5'b00100;
  localparam [4:0] ST_TX = 5'b01000;
  localparam [4:0] ST_TXACK = 5'b10000;
  localparam [1:0] PH_ADDR = 2'd0;
  localparam [1:0] PH_CMD = 2'd1;
  localparam [1:0] PH_HI = 2'd2;
  localparam [1:0] PH_LO = 2'd3;
  localparam [15:0] CODE_MASK = (TEN_BIT != 0) ? `DRG_MASK_CODE10 : `DRG_MASK_CODE8;

  reg [4:0] state;
  reg [1:0] phase;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg [7:0] cmd_ptr;
  reg [7:0] upper_data_byte;
  reg [7:0] lower_data_byte;
  reg [2:0] addr_latch;
  reg rd_mode;
  reg tx_lower;
  reg master_ack;
  reg wr_go;
  reg scl_q;
  reg sda_q;
  reg user_store_crc_error;
  reg factory_store_crc_error;
  reg [15:0] rd_data;

  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start_seen = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_seen = scl_in & scl_q & ~sda_q & sda_in;
  wire byte_done = scl_fall & (bit_cnt == `DRG_BITS_PER_BYTE);
  wire own_hit = (shreg[7:4] == `DRG_BUS_BASE) && (shreg[3:1] == addr_latch);
  wire bcast_hit = (shreg[7:1] == `DRG_BUS_BCAST) && !shreg[0]; // [RQ19]
  wire [15:0] wr_data = {upper_data_byte, lower_data_byte};
  // host is asked to wait out busy; dropping writes keeps a stray one harmless
  wire wr_ok = wr_go & ~nonvolatile_op_pending & ~output_update_busy; // [RQ3] [RQ5]
  wire we_power_op = wr_ok && (cmd_ptr == `DRG_CMD_POWER_OP);
  wire we_code = wr_ok && (cmd_ptr == `DRG_CMD_OUT_CODE);
  wire we_up = wr_ok && (cmd_ptr == `DRG_CMD_UP_MARGIN);
  wire we_lo = wr_ok && (cmd_ptr == `DRG_CMD_LO_MARGIN);
  wire we_pstat = wr_ok && (cmd_ptr == `DRG_CMD_PSTAT_BYTE);
  wire we_general = wr_ok && (cmd_ptr == `DRG_CMD_GENERAL);
  wire we_alarm = wr_ok && (cmd_ptr == `DRG_CMD_ALARM_TONE);
  wire we_trig = wr_ok && (cmd_ptr == `DRG_CMD_TRIGGERS);
  wire nv_start = we_trig & (wr_data[`DRG_TRIG_PROG] | wr_data[`DRG_TRIG_RELOAD]);

  drg_reg16 #(.RESET_VAL(`DRG_RST_POWER_OP), .WR_MASK(`DRG_MASK_ALL)) u_power_op (
    .mclk(mclk), .rst_n(rst_n), .we(we_power_op), .wdata(wr_data),
    .q(power_operation_cmd)
  ); // [RQ11]

  drg_reg16 #(.RESET_VAL(`DRG_RST_CODE), .WR_MASK(CODE_MASK)) u_out_code (
    .mclk(mclk), .rst_n(rst_n), .we(we_code), .wdata(wr_data),
    .q(output_code)
  ); // [RQ10] [RQ13]

  drg_reg16 #(.RESET_VAL(`DRG_RST_CODE), .WR_MASK(CODE_MASK)) u_up_margin (
    .mclk(mclk), .rst_n(rst_n), .we(we_up), .wdata(wr_data),
    .q(upper_margin_code)
  ); // [RQ10] [RQ14]

  drg_reg16 #(.RESET_VAL(`DRG_RST_CODE), .WR_MASK(CODE_MASK)) u_lo_margin (
    .mclk(mclk), .rst_n(rst_n), .we(we_lo), .wdata(wr_data),
    .q(lower_margin_code)
  ); // [RQ10] [RQ14]

  drg_reg16 #(.RESET_VAL(`DRG_RST_PSTAT_BYTE), .WR_MASK(`DRG_MASK_ALL)) u_pstat (
    .mclk(mclk), .rst_n(rst_n), .we(we_pstat), .wdata(wr_data),
    .q(power_status_byte)
  ); // [RQ11]

  drg_reg16 #(.RESET_VAL(`DRG_RST_GENERAL), .WR_MASK(`DRG_MASK_ALL)) u_general (
    .mclk(mclk), .rst_n(rst_n), .we(we_general), .wdata(wr_data),
    .q(general_settings)
  ); // [RQ7]

  drg_reg16 #(.RESET_VAL(`DRG_RST_ALARM_TONE), .WR_MASK(`DRG_MASK_ALL)) u_alarm (
    .mclk(mclk), .rst_n(rst_n), .we(we_alarm), .wdata(wr_data),
    .q(alarm_tone_settings)
  ); // [RQ9]

  drg_reg16 #(.RESET_VAL(`DRG_RST_TRIGGERS), .WR_MASK(`DRG_MASK_ALL)) u_trig (
    .mclk(mclk), .rst_n(rst_n), .we(we_trig), .wdata(wr_data),
    .q(action_triggers)
  ); // [RQ8]

  drg_busy u_nv_busy (
    .mclk(mclk), .rst_n(rst_n), .start(nv_start), .done(nv_op_done),
    .busy(nonvolatile_op_pending)
  ); // [RQ3] [RQ4]

  drg_busy u_upd_busy (
    .mclk(mclk), .rst_n(rst_n), .start(we_code), .done(output_update_done),
    .busy(output_update_busy)
  ); // [RQ5] [RQ6]

  // pure mux: reading changes no state anywhere
  always @* begin
    rd_data = 16'h0000;
    case (cmd_ptr)
      `DRG_CMD_STATUS: begin
        rd_data = {user_store_crc_error, factory_store_crc_error,
                   nonvolatile_op_pending, output_update_busy,
                   `DRG_ST_DONTCARE, PART_ID, REV_ID}; // [RQ1] [RQ2] [RQ15]
      end
      `DRG_CMD_GENERAL: rd_data = general_settings;
      `DRG_CMD_ALARM_TONE: rd_data = alarm_tone_settings;
      `DRG_CMD_TRIGGERS: rd_data = action_triggers;
      `DRG_CMD_OUT_CODE: rd_data = output_code;
      `DRG_CMD_UP_MARGIN: rd_data = upper_margin_code;
      `DRG_CMD_LO_MARGIN: rd_data = lower_margin_code;
      `DRG_CMD_POWER_OP: rd_data = power_operation_cmd;
      `DRG_CMD_PSTAT_BYTE: rd_data = power_status_byte;
      `DRG_CMD_BUS_REV: rd_data = `DRG_RST_BUS_REV; // [RQ12] [RQ16]
      default: rd_data = 16'h0000;
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      user_store_crc_error <= 1'b0;
      factory_store_crc_error <= 1'b0;
      nv_prog_req <= 1'b0;
      nv_reload_req <= 1'b0;
      output_update_req <= 1'b0;
    end else begin
      user_store_crc_error <= user_crc_fail; // [RQ1]
      factory_store_crc_error <= factory_crc_fail; // [RQ2]
      nv_prog_req <= we_trig & wr_data[`DRG_TRIG_PROG];
      nv_reload_req <= we_trig & wr_data[`DRG_TRIG_RELOAD];
      output_update_req <= we_code;
    end
  end

  // slave engine: samples on scl rise, changes sda after scl fall
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      phase <= PH_ADDR;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      cmd_ptr <= 8'h00;
      upper_data_byte <= 8'h00;
      lower_data_byte <= 8'h00;
      addr_latch <= 3'h0;
      rd_mode <= 1'b0;
      tx_lower <= 1'b0;
      master_ack <= 1'b0;
      wr_go <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      sda_out <= 1'b0;
      wr_go <= 1'b0;
      if (stop_seen) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (start_seen) begin
        // covers repeated start; cmd_ptr survives for the read
        state <= ST_RX;
        phase <= PH_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
        addr_latch <= dev_addr_sel;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_RX: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_in};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (byte_done) begin
              bit_cnt <= 4'h0;
              case (phase)
                PH_ADDR: begin
                  if (own_hit || bcast_hit) begin // [RQ19]
                    rd_mode <= shreg[0];
                    sda_oe <= 1'b1;
                    state <= ST_ACK;
                  end else begin
                    state <= ST_IDLE;
                  end
                end
                PH_CMD: begin
                  cmd_ptr <= shreg;
                  sda_oe <= 1'b1;
                  state <= ST_ACK;
                end
                PH_HI: begin
                  upper_data_byte <= shreg;
                  sda_oe <= 1'b1;
                  state <= ST_ACK;
                end
                default: begin
                  lower_data_byte <= shreg;
                  sda_oe <= 1'b1;
                  state <= ST_ACK;
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (phase == PH_ADDR && rd_mode) begin
                shreg <= rd_data[15:8]; // [RQ17]
                sda_oe <= ~rd_data[15];
                tx_lower <= 1'b0;
                state <= ST_TX;
              end else begin
                sda_oe <= 1'b0;
                state <= ST_RX;
                // further byte pairs rewrite the same register
                phase <= (phase == PH_LO) ? PH_HI : phase + 2'd1;
                wr_go <= (phase == PH_LO); // [RQ18]
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (byte_done) begin
              bit_cnt <= 4'h0;
              sda_oe <= 1'b0;
              state <= ST_TXACK;
            end else if (scl_fall) begin
              shreg <= {shreg[6:0], 1'b0};
              sda_oe <= ~shreg[6];
            end
          end
          ST_TXACK: begin
            if (scl_rise) begin
              master_ack <= ~sda_in;
            end else if (scl_fall) begin
              if (master_ack) begin
                // upper byte first, then lower, then wrap
                shreg <= tx_lower ? rd_data[15:8] : rd_data[7:0]; // [RQ17]
                sda_oe <= tx_lower ? ~rd_data[15] : ~rd_data[7];
                tx_lower <= ~tx_lower;
                state <= ST_TX;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// ==== verilog/drg_bank_note_placeholder_unused.v ====
/*
  intentionally empty helper file: no logic.
  assumes nothing.
*/

// ==== tb/drg_bank_properties.sv ====
/* port checker for the register bank.
   assumes it is bound onto drg_bank, one mclk domain. */
module drg_bank_properties #(
  parameter TEN_BIT = 1
) (
  input wire mclk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_oe,
  input wire nv_prog_req,
  input wire nv_reload_req,
  input wire output_update_req,
  input wire nv_op_done,
  input wire output_update_done,
  input wire [15:0] output_code,
  input wire [15:0] upper_margin_code,
  input wire [15:0] lower_margin_code,
  input wire [15:0] general_settings,
  input wire [15:0] action_triggers,
  input wire nonvolatile_op_pending,
  input wire output_update_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam [15:0] KEEP = TEN_BIT ? 16'h0FFC : 16'h0FF0;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_reset_vals:
    assert property ($rose(rst_n) |-> general_settings == 16'h01F0
      && action_triggers == 16'h0008 && output_code == 16'h0000)
    else $error("reset value wrong");
  a_code_mask:
    assert property (((output_code | upper_margin_code | lower_margin_code) & ~KEEP) == 16'h0000)
    else $error("ignored code bits kept");
  a_upd_busy_set:
    assert property (output_update_req |-> output_update_busy)
    else $error("update busy not raised");
  a_upd_busy_clear:
    assert property (output_update_busy && output_update_done |=> !output_update_busy)
    else $error("update busy not cleared");
  a_nv_busy_set:
    assert property (nv_prog_req || nv_reload_req |-> nonvolatile_op_pending
      && (action_triggers[4] || !nv_prog_req))
    else $error("nonvolatile busy not raised");
  a_nv_busy_clear:
    assert property (nonvolatile_op_pending && nv_op_done |=> !nonvolatile_op_pending)
    else $error("nonvolatile busy not cleared");
  a_busy_freeze:
    assert property (output_update_busy || nonvolatile_op_pending |=> $stable(output_code)
      && $stable(general_settings))
    else $error("register changed while busy");
  a_sda_turn:
    assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved with clock high");
endmodule

// ==== tb/drg_host.sv ====
/* two-wire bus host model: framed register writes and reads.
   assumes the bench forms sda_in from host_sda and the bank's pull. */
module drg_host (
  input wire mclk,
  input wire sda_in,
  output logic scl_in,
  output logic host_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_in = 1'b1;
    host_sda = 1'b1;
  end
  // three mclk per phase, above the two-cycle minimum
  task automatic ph(input logic c, input logic d);
    @(posedge mclk);
    scl_in <= c;
    host_sda <= d;
    repeat (2) @(posedge mclk);
  endtask
  task automatic sta();
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    ph(1'b0, 1'b0);
  endtask
  task automatic sto();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  // d high releases the line, so the same slot listens
  task automatic bit_io(input logic d, output logic q);
    ph(1'b0, d);
    ph(1'b1, d);
    q = sda_in;
    ph(1'b0, d);
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
    output logic nak);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(a, nak);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] w,
    output logic nak);
    logic [7:0] q;
    logic [3:0] k;
    sta();
    xfer({a, 1'b0}, 1'b1, q, k[0]);
    xfer(c, 1'b1, q, k[1]);
    xfer(w[15:8], 1'b1, q, k[2]);
    xfer(w[7:0], 1'b1, q, k[3]);
    sto();
    nak = |k;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [15:0] r,
    output logic nak);
    logic [7:0] q;
    logic [3:0] k;
    sta();
    xfer({a, 1'b0}, 1'b1, q, k[0]);
    xfer(c, 1'b1, q, k[1]);
    ph(1'b0, 1'b1);
    sta();
    xfer({a, 1'b1}, 1'b1, q, k[2]);
    xfer(8'hFF, 1'b0, r[15:8], k[3]);
    xfer(8'hFF, 1'b1, r[7:0], k[3]);
    sto();
    nak = |k[2:0];
  endtask
endmodule

// ==== tb/drg_bank_test.sv ====
/* self-checking bench for drg_bank over the two-wire host model.
   assumes drg_host and drg_bank_properties are compiled first. */
module drg_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [6:0] DEV = 7'h4A;
  localparam [6:0] BCAST = 7'h47;
  // arbitrary identification values
  localparam [3:0] PID = 4'h6;
  localparam [1:0] RID = 2'h2;
  localparam [15:0] ST = {10'h000, PID, RID};
  logic mclk, rst_n, user_crc_fail, factory_crc_fail, nv_op_done, output_update_done;
  logic [2:0] dev_addr_sel, dev_addr_sel_b;
  wire scl_in, host_sda, sda_in, sda_out, sda_oe, nv_prog_req, nv_reload_req;
  wire sda_oe_b;
  wire [15:0] margin8;
  wire output_update_req, nonvolatile_op_pending, output_update_busy;
  wire [15:0] power_operation_cmd, output_code, upper_margin_code, lower_margin_code;
  wire [15:0] power_status_byte, general_settings, alarm_tone_settings, action_triggers;
  int error_cnt, check_count, cyc, upd_cnt, prog_cnt, rel_cnt;
  logic [15:0] v;
  logic n;
  // open drain with pull-up, both banks may pull
  assign sda_in = host_sda & ~sda_oe & ~sda_oe_b;
  drg_bank #(.TEN_BIT(1), .PART_ID(PID), .REV_ID(RID)) dut (.mclk, .rst_n, .scl_in,
    .sda_in, .sda_out, .sda_oe, .dev_addr_sel, .user_crc_fail, .factory_crc_fail,
    .nv_op_done, .output_update_done, .nv_prog_req, .nv_reload_req, .output_update_req,
    .power_operation_cmd, .output_code, .upper_margin_code, .lower_margin_code,
    .power_status_byte, .general_settings, .alarm_tone_settings, .action_triggers,
    .nonvolatile_op_pending, .output_update_busy);
  // 8-bit variant on the same bus, so the narrow code mask is exercised too
  drg_bank #(.TEN_BIT(0), .PART_ID(PID), .REV_ID(RID)) dut_b (.mclk, .rst_n, .scl_in,
    .sda_in, .sda_out(), .sda_oe(sda_oe_b), .dev_addr_sel(dev_addr_sel_b),
    .user_crc_fail, .factory_crc_fail, .nv_op_done, .output_update_done,
    .nv_prog_req(), .nv_reload_req(), .output_update_req(), .power_operation_cmd(),
    .output_code(), .upper_margin_code(margin8), .lower_margin_code(),
    .power_status_byte(), .general_settings(), .alarm_tone_settings(),
    .action_triggers(), .nonvolatile_op_pending(), .output_update_busy());
  drg_host host (.mclk, .sda_in, .scl_in, .host_sda);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp_v);
    check_count++;
    if (got !== exp_v) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, got, exp_v);
    end
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic done_pulse(input logic nv);
    @(posedge mclk);
    nv_op_done <= nv;
    output_update_done <= ~nv;
    @(posedge mclk);
    nv_op_done <= 1'b0;
    output_update_done <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic t_reset();
    logic [7:0] cmd [10] = '{8'h01, 8'h21, 8'h25, 8'h26, 8'h78, 8'h98, 8'hD0, 8'hD1,
      8'hD2, 8'hD3};
    logic [15:0] ev [10] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h2200, ST, 16'h01F0,
      16'h0, 16'h0008};
    for (int i = 0; i < 10; i++) begin
      host.rd(DEV, cmd[i], v, n);
      chk(v, ev[i]);
    end
  endtask
  task automatic t_refuse();
    host.wr(DEV, 8'h25, 16'hFFFF, n);
    host.wr(DEV, 8'h26, 16'h1237, n);
    chk(upper_margin_code, 16'h0FFC);
    host.rd(DEV, 8'h26, v, n);
    chk(v, 16'h0234);
    host.wr(DEV, 8'hD0, 16'hFFFF, n);
    host.wr(DEV, 8'h98, 16'h1234, n);
    host.rd(DEV, 8'hD0, v, n);
    chk(v, ST);
    host.rd(DEV, 8'h98, v, n);
    chk(v, 16'h2200);
    host.wr(DEV, 8'hD2, 16'h1234, n);
    chk(alarm_tone_settings, 16'h1234);
    host.rd(DEV, 8'hD2, v, n);
    chk(v, 16'h1234);
    host.wr(7'h4B, 8'h78, 16'h00FF, n);
    chk({15'h0, n} | power_status_byte, 16'h0001);
    host.wr(BCAST, 8'h01, 16'hA55A, n);
    chk(power_operation_cmd, 16'hA55A);
    host.rd(BCAST, 8'h01, v, n);
    chk(16'(n), 16'h0001);
  endtask
  task automatic t_update();
    host.wr(DEV, 8'h21, 16'h1237, n);
    chk(output_code, 16'h0234);
    chk(upd_cnt[15:0], 16'h0001);
    host.rd(DEV, 8'hD0, v, n);
    chk(v, ST | 16'h1000);
    host.wr(DEV, 8'h21, 16'h0000, n);
    chk(output_code, 16'h0234);
    done_pulse(1'b0);
    chk(16'(output_update_busy), 16'h0000);
    host.wr(DEV, 8'h21, 16'h0FFF, n);
    chk(output_code, 16'h0FFC);
    done_pulse(1'b0);
  endtask
  task automatic t_nv();
    for (int b = 4; b < 6; b++) begin
      host.wr(DEV, 8'hD3, 16'h0008 | (16'h0001 << b), n);
      chk({prog_cnt[7:0], rel_cnt[7:0]}, b == 4 ? 16'h0100 : 16'h0101);
      host.rd(DEV, 8'hD0, v, n);
      chk(v, ST | 16'h2000);
      host.wr(DEV, 8'h78, 16'h0033, n);
      chk(power_status_byte, 16'h0000);
      host.wr(DEV, 8'hD1, 16'h0000, n);
      chk(general_settings, 16'h01F0);
      done_pulse(1'b1);
      chk(16'(nonvolatile_op_pending), 16'h0000);
    end
    host.wr(DEV, 8'h78, 16'h00C3, n);
    chk(power_status_byte, 16'h00C3);
  endtask
  task automatic t_status();
    @(posedge mclk);
    user_crc_fail <= 1'b1;
    host.rd(DEV, 8'hD0, v, n);
    chk(v, ST | 16'h8000);
    user_crc_fail <= 1'b0;
    factory_crc_fail <= 1'b1;
    host.rd(DEV, 8'hD0, v, n);
    chk(v, ST | 16'h4000);
    chk({15'h0, sda_out}, 16'h0000);
  endtask
  task automatic t_narrow();
    host.wr(7'h48, 8'h25, 16'h1237, n);
    chk(margin8, 16'h0230);
    host.rd(7'h48, 8'h25, v, n);
    chk(v, 16'h0230);
    chk(upper_margin_code, 16'h0FFC);
  endtask
  // mid-run reset: every written register except the lower margin code must fall back to its reset value
  task automatic t_rerst();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(output_code | upper_margin_code | power_status_byte, 16'h0000);
    chk(general_settings, 16'h01F0);
    chk(alarm_tone_settings | power_operation_cmd, 16'h0000);
    host.rd(DEV, 8'hD3, v, n);
    chk(v, 16'h0008);
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    upd_cnt += int'(output_update_req === 1'b1);
    prog_cnt += int'(nv_prog_req === 1'b1);
    rel_cnt += int'(nv_reload_req === 1'b1);
    if (cyc == 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    rst_n = 1'b0;
    dev_addr_sel = 3'b010;
    dev_addr_sel_b = 3'b000;
    user_crc_fail = 1'b0;
    factory_crc_fail = 1'b0;
    nv_op_done = 1'b0;
    output_update_done = 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_reset();
    t_refuse();
    t_narrow();
    t_update();
    t_nv();
    t_status();
    t_rerst();
    report_and_stop();
  end
endmodule
bind drg_bank drg_bank_properties #(.TEN_BIT(TEN_BIT)) props (.mclk, .rst_n, .scl_in,
  .sda_oe, .nv_prog_req, .nv_reload_req, .output_update_req, .nv_op_done,
  .output_update_done, .output_code, .upper_margin_code, .lower_margin_code,
  .general_settings, .action_triggers, .nonvolatile_op_pending, .output_update_busy);
